// ==== hw/dcc_pkg.sv ====
// Package for the digit code converter: register map, control and status fields, codes.
// Assumes a 32-bit classic Wishbone slave with byte addresses on a 40 MHz clock.
package dcc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SEL    = 8'h04;
  localparam logic [7:0] OFF_SRC0   = 8'h08;
  localparam logic [7:0] OFF_DST0   = 8'h14;
  localparam logic [7:0] OFF_ROOM   = 8'h24;
  localparam logic [7:0] OFF_PTR    = 8'h28;
  localparam logic [7:0] OFF_STAT   = 8'h2c;
  // Control fields
  localparam int CTRL_EXEC = 4;
  localparam int CTRL_GO   = 8;
  // Status fields
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_FAULT = 2;
  // Pointer indirect flag position
  localparam int PTR_IND = 16;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0]  RST_ROOM = 3'h4;
  // Highest word of the indirect area, BCD
  localparam logic [15:0] AREA_TOP = 16'h0999;
  // Operations
  localparam logic [1:0] OP_SEG = 2'h0;
  localparam logic [1:0] OP_CHR = 2'h1;
  localparam logic [1:0] OP_HEX = 2'h2;
  // Parity modes
  localparam logic [3:0] PAR_NONE = 4'h0;
  localparam logic [3:0] PAR_EVEN = 4'h1;
  localparam logic [3:0] PAR_ODD  = 4'h2;
  // Character bases
  localparam logic [7:0] CHR_DIG = 8'h30;
  localparam logic [7:0] CHR_LET = 8'h37;
  // Segment codes for digits 0 to f, bit 0 is segment a
  localparam logic [7:0] SEG_TAB [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27,
                                          8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  typedef enum logic {ST_IDLE, ST_RUN} dcc_state_t;
endpackage

// ==== hw/dcc_top.sv ====
// Digit code converter: segment, character and character-to-digit conversions.
// Assumes the sequencer loads operands over Wishbone, starts a run, then polls done.
//
// Function
// - Execution condition off leaves destination and fault unchanged; done still sets.
// - Segment mode writes one code per digit.
// - Bits 0-6 are segments a-g, msb zero.
// - Fixed segment table for digits 0 to f.
// - Character mode writes one character per digit.
// - Selector gives first digit, count, start half.
// - Result bytes pack in order across words.
// - Digit index wraps back to digit zero.
// - No parity forces character msb to zero.
// - Even parity makes an even bit count.
// - Odd parity makes an odd bit count.
// - Bad selector or area overrun raises fault.
// - Bad indirect pointer raises fault.
// - Character bytes become digits of one word.
// - At most four bytes, selector picks start.
// - Source bytes run through three source words.
// - Destination digit wraps; others keep contents.
// - Digits map to 30-39 and 41-46.
// - Source parity mismatch faults, destination kept.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dcc_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  logic [15:0]      ctrl_q;
  logic [15:0]      sel_q;
  logic [2:0][15:0] src_q;
  logic [3:0][15:0] dst_q;
  logic [3:0][15:0] dst_d;
  logic [2:0]       room_q;
  logic [16:0]      ptr_q;
  logic             done_q;
  logic             fault_q;
  dcc_pkg::dcc_state_t state_q;
  logic             acc;
  logic             wr;
  logic [15:0]      wm;
  logic [15:0]      wv;
  logic             go;
  logic             run;
  logic [1:0]       op;
  logic             exec;
  logic [3:0]       f0;
  logic [3:0]       f1;
  logic [3:0]       f2;
  logic [3:0]       par;
  logic [2:0]       cnt;
  logic [3:0][3:0]  nib_v;
  logic [3:0][7:0]  seg_v;
  logic [3:0][7:0]  chr_v;
  logic [3:0][3:0]  hex_v;
  logic [3:0]       perr_v;
  logic             sel_bad;
  logic             area_bad;
  logic             ind_bad;
  logic             par_bad;
  logic             fault_now;

  // Bus decode and byte-lane write mask
  assign acc  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr   = acc & wb_we_i;
  assign wm   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wv   = wb_dat_i[15:0] & wm;
  assign go   = wr & (wb_adr_i == dcc_pkg::OFF_CTRL) & wb_sel_i[1] & wb_dat_i[dcc_pkg::CTRL_GO];
  assign run  = (state_q == dcc_pkg::ST_RUN);

  // Control and selector fields
  assign op   = ctrl_q[1:0];
  assign exec = ctrl_q[dcc_pkg::CTRL_EXEC];
  assign f0   = sel_q[3:0];
  assign f1   = sel_q[7:4];
  assign f2   = sel_q[11:8];
  assign par  = sel_q[15:12];
  assign cnt  = 3'(f1[1:0]) + 3'h1;

  // Per-entry conversions
  for (genvar i = 0; i < 4; i++) begin : g_ent
    logic [1:0] di;
    logic [2:0] bi;
    logic [7:0] base;
    logic [7:0] hb;
    assign di  = 2'(f0[1:0] + 2'(i));
    assign nib_v[i] = src_q[0][di*4 +: 4];
    assign seg_v[i] = dcc_pkg::SEG_TAB[nib_v[i]];
    assign base = (nib_v[i] < 4'ha) ? (dcc_pkg::CHR_DIG + 8'(nib_v[i]))
                                    : (dcc_pkg::CHR_LET + 8'(nib_v[i]));
    always_comb begin
      unique case (par)
        dcc_pkg::PAR_EVEN: chr_v[i] = {^base[6:0], base[6:0]};
        dcc_pkg::PAR_ODD:  chr_v[i] = {~^base[6:0], base[6:0]};
        default:           chr_v[i] = {1'b0, base[6:0]};
      endcase
    end
    // Source byte walk from chosen half of first word
    assign bi = 3'(f0[0]) + 3'(i);
    assign hb = src_q[bi[2:1]][bi[0]*8 +: 8];
    assign hex_v[i] = hb[6] ? 4'(hb[3:0] + 4'h9) : hb[3:0];
    always_comb begin
      unique case (par)
        dcc_pkg::PAR_EVEN: perr_v[i] = ^hb;
        dcc_pkg::PAR_ODD:  perr_v[i] = ~^hb;
        default:           perr_v[i] = hb[7];
      endcase
    end
  end

  // Fault checks
  always_comb begin
    sel_bad = 1'b0;
    par_bad = 1'b0;
    unique case (op)
      dcc_pkg::OP_SEG: sel_bad = (f0 > 4'h3) | (f1 > 4'h3) | (f2 > 4'h1) | (par != 4'h0);
      dcc_pkg::OP_CHR: sel_bad = (f0 > 4'h3) | (f1 > 4'h3) | (f2 > 4'h1) | (par > dcc_pkg::PAR_ODD);
      dcc_pkg::OP_HEX: begin
        sel_bad = (f0 > 4'h1) | (f1 > 4'h3) | (f2 > 4'h3) | (par > dcc_pkg::PAR_ODD);
        for (int i = 0; i < 4; i++) begin
          if (3'(i) < cnt) begin
            par_bad = par_bad | perr_v[i];
          end
        end
      end
      default: sel_bad = 1'b1;
    endcase
  end
  // Words needed must fit the room left in the area
  assign area_bad  = (op != dcc_pkg::OP_HEX) &
                     (((3'(f2[0]) + cnt + 3'h1) >> 1) > room_q);
  assign ind_bad   = ptr_q[dcc_pkg::PTR_IND] &
                     ((ptr_q[3:0] > 4'h9) | (ptr_q[7:4] > 4'h9) | (ptr_q[11:8] > 4'h9) |
                      (ptr_q[15:12] > 4'h9) | (ptr_q[15:0] > dcc_pkg::AREA_TOP));
  assign fault_now = sel_bad | area_bad | ind_bad | par_bad;

  // Result image: untouched bytes and digits keep old contents
  always_comb begin
    logic [2:0] slot;
    logic [1:0] dg;
    slot  = 3'h0;
    dg    = 2'h0;
    dst_d = dst_q;
    for (int i = 0; i < 4; i++) begin
      slot = 3'(f2[0]) + 3'(i);
      dg   = 2'(f2[1:0] + 2'(i));
      if (3'(i) < cnt) begin
        if (op == dcc_pkg::OP_SEG) begin
          dst_d[slot[2:1]][slot[0]*8 +: 8] = seg_v[i];
        end else if (op == dcc_pkg::OP_CHR) begin
          dst_d[slot[2:1]][slot[0]*8 +: 8] = chr_v[i];
        end else begin
          dst_d[0][dg*4 +: 4] = hex_v[i];
        end
      end
    end
  end

  // Sequencer: go starts one run cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= dcc_pkg::ST_IDLE;
    end else if (go & ~run) begin
      state_q <= dcc_pkg::ST_RUN;
    end else begin
      state_q <= dcc_pkg::ST_IDLE;
    end
  end

  // Done and fault: set wins over write-one clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done_q  <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      if (run) begin
        done_q <= 1'b1;
      end else if (go | (wr & (wb_adr_i == dcc_pkg::OFF_STAT) & wb_sel_i[0] & wb_dat_i[dcc_pkg::STAT_DONE])) begin
        done_q <= 1'b0;
      end
      if (run & exec & fault_now) begin
        fault_q <= 1'b1;
      end else if (wr & (wb_adr_i == dcc_pkg::OFF_STAT) & wb_sel_i[0] & wb_dat_i[dcc_pkg::STAT_FAULT]) begin
        fault_q <= 1'b0;
      end
    end
  end

  // Destination words: conversion wins over bus writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dst_q <= '0;
    end else if (run) begin
      if (exec & ~fault_now) begin
        dst_q <= dst_d;
      end
    end else if (wr && wb_adr_i >= dcc_pkg::OFF_DST0 && wb_adr_i < dcc_pkg::OFF_ROOM) begin
      dst_q[2'((wb_adr_i - dcc_pkg::OFF_DST0) >> 2)] <=
        (dst_q[2'((wb_adr_i - dcc_pkg::OFF_DST0) >> 2)] & ~wm) | wv;
    end
  end

  // Operand and control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= dcc_pkg::RST_WORD;
      sel_q  <= dcc_pkg::RST_WORD;
      src_q  <= '0;
      room_q <= dcc_pkg::RST_ROOM;
      ptr_q  <= '0;
    end else if (wr & ~run) begin
      if (wb_adr_i == dcc_pkg::OFF_CTRL) begin
        ctrl_q <= (ctrl_q & ~wm) | wv;
      end
      if (wb_adr_i == dcc_pkg::OFF_SEL) begin
        sel_q <= (sel_q & ~wm) | wv;
      end
      if (wb_adr_i >= dcc_pkg::OFF_SRC0 && wb_adr_i < dcc_pkg::OFF_DST0) begin
        src_q[2'((wb_adr_i - dcc_pkg::OFF_SRC0) >> 2)] <=
          (src_q[2'((wb_adr_i - dcc_pkg::OFF_SRC0) >> 2)] & ~wm) | wv;
      end
      if (wb_adr_i == dcc_pkg::OFF_ROOM && wb_sel_i[0]) begin
        room_q <= wb_dat_i[2:0];
      end
      if (wb_adr_i == dcc_pkg::OFF_PTR) begin
        ptr_q[15:0] <= (ptr_q[15:0] & ~wm) | wv;
        if (wb_sel_i[2]) begin
          ptr_q[dcc_pkg::PTR_IND] <= wb_dat_i[dcc_pkg::PTR_IND];
        end
      end
    end
  end

  // Acknowledge and read data, one cycle after request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= '0;
      if (acc & ~wb_we_i) begin
        unique case (wb_adr_i)
          dcc_pkg::OFF_CTRL: wb_dat_o <= {16'h0000, ctrl_q & 16'h00ff};
          dcc_pkg::OFF_SEL:  wb_dat_o <= {16'h0000, sel_q};
          8'h08, 8'h0c, 8'h10: wb_dat_o <= {16'h0000, src_q[2'((wb_adr_i - dcc_pkg::OFF_SRC0) >> 2)]};
          8'h14, 8'h18, 8'h1c, 8'h20: wb_dat_o <= {16'h0000, dst_q[2'((wb_adr_i - dcc_pkg::OFF_DST0) >> 2)]};
          dcc_pkg::OFF_ROOM: wb_dat_o <= {29'h0, room_q};
          dcc_pkg::OFF_PTR:  wb_dat_o <= {15'h0, ptr_q};
          dcc_pkg::OFF_STAT: wb_dat_o <= {29'h0, fault_q, done_q, run | go};
          default:           wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_start;
    go & ~run;
  endsequence
  sequence s_finish;
    run ##1 done_q;
  endsequence

  property p_noexec;
    run & ~exec |=> $stable(dst_q) && $stable(fault_q);
  endproperty
  a_noexec: assert property (p_noexec) else $error("dst changed with exec off");

  property p_seg_tab;
    nib_v[0] == 4'h8 |-> seg_v[0] == 8'h7f && seg_v[0][7] == 1'b0;
  endproperty
  a_seg_tab: assert property (p_seg_tab) else $error("bad segment code");

  property p_seg_wr;
    run & exec & ~fault_now & (op == dcc_pkg::OP_SEG) & (f2 == 4'h0) |=> dst_q[0][7:0] == $past(seg_v[0]);
  endproperty
  a_seg_wr: assert property (p_seg_wr) else $error("segment byte not written");

  property p_even;
    par == dcc_pkg::PAR_EVEN |-> ^chr_v[1] == 1'b0;
  endproperty
  a_even: assert property (p_even) else $error("even parity wrong");

  property p_odd;
    par == dcc_pkg::PAR_ODD |-> ^chr_v[2] == 1'b1;
  endproperty
  a_odd: assert property (p_odd) else $error("odd parity wrong");

  property p_nopar;
    par == dcc_pkg::PAR_NONE |-> chr_v[3][7] == 1'b0;
  endproperty
  a_nopar: assert property (p_nopar) else $error("msb set without parity");

  property p_fault;
    run & exec & sel_bad |=> fault_q && $stable(dst_q);
  endproperty
  a_fault: assert property (p_fault) else $error("bad selector not faulted");

  property p_hexpar;
    run & exec & par_bad |=> fault_q && $stable(dst_q);
  endproperty
  a_hexpar: assert property (p_hexpar) else $error("parity error not faulted");

  property p_done;
    s_start |=> s_finish;
  endproperty
  a_done: assert property (p_done) else $error("done not within two cycles");
endmodule

// ==== bench/dcc_seq_model.sv ====
// Sequencer model: classic Wishbone master that loads operands and polls status.
// Assumes a single clock and a slave that acks every request.
`timescale 1ns/1ps
module dcc_seq_model (
  // Clock
  input  wire logic        mclk,
  // Slave answer
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  // Master request
  output logic             wb_cyc_i,
  output logic             wb_stb_i,
  output logic             wb_we_i,
  output logic      [7:0]  wb_adr_i,
  output logic      [31:0] wb_dat_i,
  output logic      [3:0]  wb_sel_i
);
  // Idle bus from time zero
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'h0;
  end

  // One bus cycle; request held until ack is sampled, one idle cycle after
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d; // Operands stay put for the whole access
    wb_sel_i <= 4'hf;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
endmodule

// ==== bench/tb.sv ====
// Testbench for the digit code converter: conversions, faults, register access.
// Assumes the sequencer model drives the bus and the design holds its own assertions.
`timescale 1ns/1ps
module tb;
  // Clock, reset and bus
  logic        mclk;
  logic        rst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  int          num_errors = 0;
  int          checked = 0;
  // Segment codes for digits 0 to f
  logic [7:0]  seg_exp [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27,
                                 8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};

  dcc_top i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  dcc_seq_model i_seq (.mclk(mclk), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i));

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_seq.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    i_seq.xfer(1'b0, a, 32'h0, q);
  endtask

  // Start a conversion, poll until done, then clear done and fault
  task automatic run(input logic [1:0] op, input logic ex, output logic [31:0] st);
    wr(dcc_pkg::OFF_CTRL, 32'h100 | {27'h0, ex, 2'h0, op});
    st = 32'h0;
    while (st[1] !== 1'b1) rd(dcc_pkg::OFF_STAT, st); // Wait for done
    wr(dcc_pkg::OFF_STAT, 32'h6);
  endtask

  // Expected character for a digit under a parity mode
  function automatic logic [7:0] chr_of(logic [3:0] d, logic [3:0] p);
    logic [7:0] c;
    c = (d < 4'ha) ? 8'h30 + 8'(d) : 8'h41 + 8'(d - 4'ha);
    if (p == dcc_pkg::PAR_EVEN) c[7] = ^c[6:0];
    else if (p == dcc_pkg::PAR_ODD) c[7] = ~^c[6:0];
    return c;
  endfunction

  task automatic t_reset();
    logic [31:0] q;
    rd(dcc_pkg::OFF_ROOM, q); chk(q, 32'h4);
    rd(dcc_pkg::OFF_STAT, q); chk(q, 32'h0);
    rd(dcc_pkg::OFF_SEL, q); chk(q, 32'h0);
    wr(8'h30, 32'hffff);
    rd(8'h30, q); chk(q, 32'h0);
  endtask

  // All sixteen digits, four per run, low half first
  task automatic t_seg();
    logic [31:0] q;
    for (int k = 0; k < 4; k++) begin
      wr(dcc_pkg::OFF_SRC0, {16'h0, 4'(4*k+3), 4'(4*k+2), 4'(4*k+1), 4'(4*k)});
      wr(dcc_pkg::OFF_SEL, 32'h30);
      run(dcc_pkg::OP_SEG, 1'b1, q);
      chk(q[2], 1'b0);
      rd(dcc_pkg::OFF_DST0, q);
      chk(q, {16'h0, seg_exp[4*k+1], seg_exp[4*k]});
      rd(dcc_pkg::OFF_DST0 + 8'h04, q);
      chk(q, {16'h0, seg_exp[4*k+3], seg_exp[4*k+2]});
    end
  endtask

  // Start at digit 3 in the high half, wrap to digit 0, every parity mode
  task automatic t_chr();
    logic [31:0] q;
    logic [3:0]  p;
    for (int m = 0; m < 3; m++) begin
      p = 4'(m);
      wr(dcc_pkg::OFF_SRC0, 32'h9a5c);
      wr(dcc_pkg::OFF_SEL, {16'h0, p, 12'h123});
      run(dcc_pkg::OP_CHR, 1'b1, q);
      rd(dcc_pkg::OFF_DST0, q);
      chk(q[15:8], chr_of(4'h9, p));
      rd(dcc_pkg::OFF_DST0 + 8'h04, q);
      chk(q[15:0], {chr_of(4'h5, p), chr_of(4'hc, p)});
    end
  endtask

  // Refused runs leave the destination alone
  task automatic t_fault();
    logic [31:0] q;
    logic [2:0]  room [7] = '{3'h1, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};
    logic [16:0] ptr  [7] = '{17'h0, 17'h0, 17'h0, 17'h10a00, 17'h11000, 17'h0, 17'h0};
    logic [15:0] sel  [7] = '{16'h0020, 16'h0, 16'h1000, 16'h0, 16'h0, 16'h0, 16'h1000};
    logic [1:0]  op   [7] = '{2'h0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    logic        ex   [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic        flt  [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 7; i++) begin
      wr(dcc_pkg::OFF_DST0, 32'h1234);
      wr(dcc_pkg::OFF_SRC0, 32'h0008);
      wr(dcc_pkg::OFF_ROOM, {29'h0, room[i]});
      wr(dcc_pkg::OFF_PTR, {15'h0, ptr[i]});
      wr(dcc_pkg::OFF_SEL, {16'h0, sel[i]});
      run(op[i], ex[i], q);
      chk(q[2], flt[i]);
      rd(dcc_pkg::OFF_DST0, q);
      chk(q, 32'h1234);
    end
    wr(dcc_pkg::OFF_ROOM, 32'h4);
    wr(dcc_pkg::OFF_PTR, 32'h0);
  endtask

  // Source characters are hex digits only
  task automatic t_hex();
    logic [31:0] q;
    logic [15:0] sel [5] = '{16'h0230, 16'h0311, 16'h1030, 16'h2000, 16'h0031};
    logic [15:0] exp [5] = '{16'ha1f9, 16'ha559, 16'ha559, 16'ha551, 16'hbf9a};
    logic        flt [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    wr(dcc_pkg::OFF_SRC0, 32'h4131);
    wr(dcc_pkg::OFF_SRC0 + 8'h04, 32'h6639);
    wr(dcc_pkg::OFF_SRC0 + 8'h08, 32'h0062);
    for (int i = 0; i < 5; i++) begin
      if (i < 2) wr(dcc_pkg::OFF_DST0, 32'h5555);
      wr(dcc_pkg::OFF_SEL, {16'h0, sel[i]});
      run(dcc_pkg::OP_HEX, 1'b1, q);
      chk(q[2], flt[i]);
      rd(dcc_pkg::OFF_DST0, q);
      chk(q, {16'h0, exp[i]});
    end
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_seg();
    t_chr();
    t_fault();
    t_hex();
    give_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
endmodule
